// *** core/cxs_defines.vh ***
// Constants for the exception entry sequencer: offsets, fields, reset values, event table
`ifndef CXS_DEFINES_VH
`define CXS_DEFINES_VH

// APB byte offsets
`define CXS_ADDR_CTRL 8'h00
`define CXS_ADDR_VBASE 8'h04
`define CXS_ADDR_DBASE 8'h08
`define CXS_ADDR_STATUS 8'h0c
`define CXS_ADDR_SPC 8'h10
`define CXS_ADDR_SST 8'h14
`define CXS_ADDR_EXCEVT 8'h18
`define CXS_ADDR_IRQEVT 8'h1c
`define CXS_ADDR_INFO 8'h20

// Register select codes
`define CXS_SEL_CTRL 4'h0
`define CXS_SEL_VBASE 4'h1
`define CXS_SEL_DBASE 4'h2
`define CXS_SEL_STATUS 4'h3
`define CXS_SEL_SPC 4'h4
`define CXS_SEL_SST 4'h5
`define CXS_SEL_EXCEVT 4'h6
`define CXS_SEL_IRQEVT 4'h7
`define CXS_SEL_INFO 4'h8
`define CXS_SEL_NONE 4'hf

// Status word fields
`define CXS_SR_BLOCK 0
`define CXS_SR_PRIV 1
`define CXS_SR_BANK 2
`define CXS_SR_FPUOFF 3
`define CXS_SR_RESET 32'h0000000f
`define CXS_CTRL_DBG 0

// Reset values of event registers
`define CXS_EXCEVT_POR 12'h000
`define CXS_IRQEVT_RESET 12'h000

// Vectors and offsets
`define CXS_RESET_VEC 32'ha0000000
`define CXS_OFF_GEN 32'h00000100
`define CXS_OFF_TLB 32'h00000400
`define CXS_OFF_IRQ 32'h00000600

// Offset classes
`define CXS_OC_RESET 2'h0
`define CXS_OC_GEN 2'h1
`define CXS_OC_TLB 2'h2
`define CXS_OC_IRQ 2'h3

// Event codes
`define CXS_CODE_POR 12'h000
`define CXS_CODE_MRST 12'h020
`define CXS_CODE_MHIT 12'h140
`define CXS_CODE_UBRK 12'h1e0
`define CXS_CODE_ADRI 12'h0e0
`define CXS_CODE_TLBR 12'h040
`define CXS_CODE_TLBW 12'h060
`define CXS_CODE_PROTR 12'h0a0
`define CXS_CODE_PROTW 12'h0c0
`define CXS_CODE_ILL 12'h180
`define CXS_CODE_SILL 12'h1a0
`define CXS_CODE_FOFF 12'h800
`define CXS_CODE_SFOFF 12'h820
`define CXS_CODE_TRAP 12'h160
`define CXS_CODE_ADRW 12'h100
`define CXS_CODE_FPU 12'h120
`define CXS_CODE_IPW 12'h080
`define CXS_CODE_NMI 12'h1c0

// Event indices, ordered by priority level then order
`define CXS_EV_POR 5'd0
`define CXS_EV_DBGRST 5'd1
`define CXS_EV_MRST 5'd2
`define CXS_EV_IMHIT 5'd3
`define CXS_EV_DMHIT 5'd4
`define CXS_EV_UBRK_PRE 5'd5
`define CXS_EV_IADR 5'd6
`define CXS_EV_ITLB 5'd7
`define CXS_EV_IPROT 5'd8
`define CXS_EV_ILL 5'd9
`define CXS_EV_SILL 5'd10
`define CXS_EV_FOFF 5'd11
`define CXS_EV_SFOFF 5'd12
`define CXS_EV_TRAP 5'd13
`define CXS_EV_DADR_R 5'd14
`define CXS_EV_DADR_W 5'd15
`define CXS_EV_DTLB_R 5'd16
`define CXS_EV_DTLB_W 5'd17
`define CXS_EV_DPROT_R 5'd18
`define CXS_EV_DPROT_W 5'd19
`define CXS_EV_FPU 5'd20
`define CXS_EV_IPW 5'd21
`define CXS_EV_UBRK_POST 5'd22
`define CXS_EV_NUM 23

`endif

// *** core/cxs_evt_pick.v ***
// Priority picker and event table for the exception entry sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cxs_defines.vh"

module cxs_evt_pick #(
	parameter EV_NUM = `CXS_EV_NUM
) (
	input wire [EV_NUM-1:0] evt_req,
	input wire nmi_req,
	input wire irq_req,
	input wire [11:0] irq_code,
	input wire block,
	output reg hit,
	output reg is_irq,
	output reg [4:0] idx,
	output reg [11:0] code,
	output reg [1:0] off_cls,
	output reg is_reset,
	output reg is_compl,
	output reg is_dbg
);

function [11:0] ev_code;
	input [4:0] i;
	begin
		case (i)
			`CXS_EV_POR, `CXS_EV_DBGRST: ev_code = `CXS_CODE_POR;
			`CXS_EV_MRST: ev_code = `CXS_CODE_MRST;
			`CXS_EV_IMHIT, `CXS_EV_DMHIT: ev_code = `CXS_CODE_MHIT;
			`CXS_EV_UBRK_PRE, `CXS_EV_UBRK_POST: ev_code = `CXS_CODE_UBRK;
			`CXS_EV_IADR, `CXS_EV_DADR_R: ev_code = `CXS_CODE_ADRI;
			`CXS_EV_DADR_W: ev_code = `CXS_CODE_ADRW;
			`CXS_EV_ITLB, `CXS_EV_DTLB_R: ev_code = `CXS_CODE_TLBR;
			`CXS_EV_DTLB_W: ev_code = `CXS_CODE_TLBW;
			`CXS_EV_IPROT, `CXS_EV_DPROT_R: ev_code = `CXS_CODE_PROTR;
			`CXS_EV_DPROT_W: ev_code = `CXS_CODE_PROTW;
			`CXS_EV_ILL: ev_code = `CXS_CODE_ILL;
			`CXS_EV_SILL: ev_code = `CXS_CODE_SILL;
			`CXS_EV_FOFF: ev_code = `CXS_CODE_FOFF;
			`CXS_EV_SFOFF: ev_code = `CXS_CODE_SFOFF;
			`CXS_EV_TRAP: ev_code = `CXS_CODE_TRAP;
			`CXS_EV_FPU: ev_code = `CXS_CODE_FPU;
			`CXS_EV_IPW: ev_code = `CXS_CODE_IPW;
			default: ev_code = `CXS_CODE_POR;
		endcase
	end
endfunction

integer k;

always @*
begin
	hit = 1'b0;
	is_irq = 1'b0;
	idx = 5'd0;
	// Scan downward so the lowest index, the highest priority, wins
	for (k = EV_NUM - 1; k >= 0; k = k - 1)
	begin
		if (evt_req[k])
		begin
			hit = 1'b1;
			idx = k[4:0];
		end
	end
	code = ev_code(idx);
	is_reset = (idx <= `CXS_EV_DMHIT);
	is_compl = (idx == `CXS_EV_TRAP) || (idx == `CXS_EV_UBRK_POST);
	is_dbg = (idx == `CXS_EV_UBRK_PRE) || (idx == `CXS_EV_UBRK_POST);
	if (is_reset)
		off_cls = `CXS_OC_RESET;
	else if (idx == `CXS_EV_ITLB || idx == `CXS_EV_DTLB_R || idx == `CXS_EV_DTLB_W)
		off_cls = `CXS_OC_TLB;
	else
		off_cls = `CXS_OC_GEN;
	// Interrupts rank below every exception and wait while blocked
	if (!hit && !block && (nmi_req || irq_req))
	begin
		hit = 1'b1;
		is_irq = 1'b1;
		is_reset = 1'b0;
		is_compl = 1'b1;
		is_dbg = 1'b0;
		off_cls = `CXS_OC_IRQ;
		code = nmi_req ? `CXS_CODE_NMI : irq_code;
	end
end

endmodule
`default_nettype wire

// *** core/cxs_exc_seq.v ***
// Exception entry and return sequencer with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "cxs_defines.vh"

module cxs_exc_seq #(
	parameter ADDR_W = 8,
	parameter EV_NUM = `CXS_EV_NUM
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg pready_q,
	output reg [31:0] prdata_q,
	output reg pslverr_q,
	input wire [EV_NUM-1:0] evt_req,
	input wire nmi_req,
	input wire irq_req,
	input wire [11:0] irq_code,
	input wire rte_req,
	input wire [31:0] cur_pc,
	input wire [31:0] next_pc,
	output reg redirect_q,
	output reg [31:0] redirect_pc_q,
	output reg exc_ack_q,
	output reg irq_ack_q,
	output reg rte_ack_q,
	output reg [31:0] status_q
);

////////////////////////////////////////////////////////////////////////////////

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_GAP = 2'b10;

reg [1:0] state_q;
reg [1:0] state_d;
reg ctrl_dbg_q;
reg [31:0] vbase_q;
reg [31:0] dbase_q;
reg [31:0] saved_pc_q;
reg [31:0] saved_status_q;
reg [11:0] exc_evt_q;
reg [11:0] irq_evt_q;
reg [5:0] info_q;

wire pk_hit;
wire pk_irq;
wire [4:0] pk_idx;
wire [11:0] pk_code;
wire [1:0] pk_off;
wire pk_reset;
wire pk_compl;
wire pk_dbg;

reg take;
reg ret;
reg [31:0] vec_d;
reg [31:0] sr_entry;
reg [31:0] rd_mux;
reg [3:0] rd_sel;

wire apb_done;
wire apb_wr;
wire [3:0] wr_sel;

////////////////////////////////////////////////////////////////////////////////

function [3:0] reg_sel;
	input [ADDR_W-1:0] a;
	begin
		case (a)
			`CXS_ADDR_CTRL: reg_sel = `CXS_SEL_CTRL;
			`CXS_ADDR_VBASE: reg_sel = `CXS_SEL_VBASE;
			`CXS_ADDR_DBASE: reg_sel = `CXS_SEL_DBASE;
			`CXS_ADDR_STATUS: reg_sel = `CXS_SEL_STATUS;
			`CXS_ADDR_SPC: reg_sel = `CXS_SEL_SPC;
			`CXS_ADDR_SST: reg_sel = `CXS_SEL_SST;
			`CXS_ADDR_EXCEVT: reg_sel = `CXS_SEL_EXCEVT;
			`CXS_ADDR_IRQEVT: reg_sel = `CXS_SEL_IRQEVT;
			`CXS_ADDR_INFO: reg_sel = `CXS_SEL_INFO;
			default: reg_sel = `CXS_SEL_NONE;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////

cxs_evt_pick #(
	.EV_NUM(EV_NUM)
) u_pick (
	.evt_req(evt_req),
	.nmi_req(nmi_req),
	.irq_req(irq_req),
	.irq_code(irq_code),
	.block(status_q[`CXS_SR_BLOCK]),
	.hit(pk_hit),
	.is_irq(pk_irq),
	.idx(pk_idx),
	.code(pk_code),
	.off_cls(pk_off),
	.is_reset(pk_reset),
	.is_compl(pk_compl),
	.is_dbg(pk_dbg)
);

////////////////////////////////////////////////////////////////////////////////

// One gap cycle after each action lets the pipeline drop its request
always @*
begin
	take = 1'b0;
	ret = 1'b0;
	state_d = state_q;
	case (state_q)
		ST_IDLE:
		begin
			if (pk_hit)
			begin
				take = 1'b1;
				state_d = ST_GAP;
			end
			else if (rte_req)
			begin
				ret = 1'b1;
				state_d = ST_GAP;
			end
		end
		ST_GAP:
			state_d = ST_IDLE;
		default:
			state_d = ST_IDLE;
	endcase
end

always @*
begin
	case (pk_off)
		`CXS_OC_RESET: vec_d = `CXS_RESET_VEC;
		`CXS_OC_TLB: vec_d = vbase_q + `CXS_OFF_TLB;
		`CXS_OC_IRQ: vec_d = vbase_q + `CXS_OFF_IRQ;
		default: vec_d = vbase_q + `CXS_OFF_GEN;
	endcase
	// Debug base replaces the vector outright, with no offset
	if (pk_dbg && ctrl_dbg_q)
		vec_d = dbase_q;
end

always @*
begin
	sr_entry = status_q;
	sr_entry[`CXS_SR_BLOCK] = 1'b1;
	sr_entry[`CXS_SR_PRIV] = 1'b1;
	sr_entry[`CXS_SR_BANK] = 1'b1;
	if (pk_reset)
		sr_entry[`CXS_SR_FPUOFF] = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		state_q <= ST_IDLE;
		redirect_q <= 1'b0;
		redirect_pc_q <= 32'h00000000;
		exc_ack_q <= 1'b0;
		irq_ack_q <= 1'b0;
		rte_ack_q <= 1'b0;
		saved_pc_q <= 32'h00000000;
		saved_status_q <= 32'h00000000;
		info_q <= 6'h00;
	end
	else
	begin
		state_q <= state_d;
		redirect_q <= take | ret;
		exc_ack_q <= take & ~pk_irq;
		irq_ack_q <= take & pk_irq;
		rte_ack_q <= ret;
		if (take)
		begin
			redirect_pc_q <= vec_d;
			saved_pc_q <= pk_compl ? next_pc : cur_pc;
			saved_status_q <= status_q;
			info_q <= {pk_irq, pk_idx};
		end
		else if (ret)
		begin
			redirect_pc_q <= saved_pc_q;
		end
		else
		begin
			if (apb_wr && wr_sel == `CXS_SEL_SPC)
				saved_pc_q <= pwdata;
			if (apb_wr && wr_sel == `CXS_SEL_SST)
				saved_status_q <= pwdata;
		end
	end
end

// Hardware updates win over a software write in the same cycle
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		status_q <= `CXS_SR_RESET;
		exc_evt_q <= `CXS_EXCEVT_POR;
		irq_evt_q <= `CXS_IRQEVT_RESET;
	end
	else
	begin
		if (take)
			status_q <= sr_entry;
		else if (ret)
			status_q <= saved_status_q;
		else if (apb_wr && wr_sel == `CXS_SEL_STATUS)
			status_q <= pwdata;
		if (take && !pk_irq)
			exc_evt_q <= pk_code;
		else if (apb_wr && wr_sel == `CXS_SEL_EXCEVT)
			exc_evt_q <= pwdata[11:0];
		if (take && pk_irq)
			irq_evt_q <= pk_code;
		else if (apb_wr && wr_sel == `CXS_SEL_IRQEVT)
			irq_evt_q <= pwdata[11:0];
	end
end

////////////////////////////////////////////////////////////////////////////////

// APB slave, one wait state: pready rises in the second access cycle
assign apb_done = psel & penable & pready_q;
assign apb_wr = apb_done & pwrite;
assign wr_sel = reg_sel(paddr);

always @*
begin
	rd_sel = reg_sel(paddr);
	case (rd_sel)
		`CXS_SEL_CTRL: rd_mux = {31'h00000000, ctrl_dbg_q};
		`CXS_SEL_VBASE: rd_mux = vbase_q;
		`CXS_SEL_DBASE: rd_mux = dbase_q;
		`CXS_SEL_STATUS: rd_mux = status_q;
		`CXS_SEL_SPC: rd_mux = saved_pc_q;
		`CXS_SEL_SST: rd_mux = saved_status_q;
		`CXS_SEL_EXCEVT: rd_mux = {20'h00000, exc_evt_q};
		`CXS_SEL_IRQEVT: rd_mux = {20'h00000, irq_evt_q};
		`CXS_SEL_INFO: rd_mux = {26'h0000000, info_q};
		default: rd_mux = 32'h00000000;
	endcase
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pready_q <= 1'b0;
		prdata_q <= 32'h00000000;
		pslverr_q <= 1'b0;
		ctrl_dbg_q <= 1'b0;
		vbase_q <= 32'h00000000;
		dbase_q <= 32'h00000000;
	end
	else
	begin
		pready_q <= psel & penable & ~pready_q;
		if (psel && penable && !pready_q)
		begin
			prdata_q <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_q <= (rd_sel == `CXS_SEL_NONE);
		end
		else
		begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		if (apb_wr && wr_sel == `CXS_SEL_CTRL)
			ctrl_dbg_q <= pwdata[`CXS_CTRL_DBG];
		if (apb_wr && wr_sel == `CXS_SEL_VBASE)
			vbase_q <= pwdata;
		if (apb_wr && wr_sel == `CXS_SEL_DBASE)
			dbase_q <= pwdata;
	end
end

endmodule
`default_nettype wire

// *** test/cxs_exc_seq_checker.sv ***
// Port checker for the exception entry sequencer
`timescale 1ns/1ps
`default_nettype none
module cxs_exc_seq_checker #(
	parameter ADDR_W = 8,
	parameter EV_NUM = 23
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready_q,
	input wire [31:0] prdata_q,
	input wire pslverr_q,
	input wire [EV_NUM-1:0] evt_req,
	input wire redirect_q,
	input wire [31:0] redirect_pc_q,
	input wire exc_ack_q,
	input wire irq_ack_q,
	input wire rte_ack_q,
	input wire [31:0] status_q
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	property p_one;
		redirect_q |-> $onehot({exc_ack_q, irq_ack_q, rte_ack_q}) ##1 !redirect_q;
	endproperty
	a_one: assert property (p_one) else $error("redirect without single ack");
	property p_flags;
		exc_ack_q || irq_ack_q |-> status_q[2:0] == 3'h7;
	endproperty
	a_flags: assert property (p_flags) else $error("entry flags not set");
	property p_rvec;
		exc_ack_q && $past(|evt_req[4:0]) |-> redirect_pc_q == 32'ha0000000;
	endproperty
	a_rvec: assert property (p_rvec) else $error("reset vector wrong");
	property p_fdclr;
		exc_ack_q && $past(|evt_req[4:0]) |-> !status_q[3];
	endproperty
	a_fdclr: assert property (p_fdclr) else $error("fpu off flag not cleared");
	property p_fdkeep;
		(irq_ack_q || exc_ack_q && !$past(|evt_req[4:0])) |-> status_q[3] == $past(status_q[3]);
	endproperty
	a_fdkeep: assert property (p_fdkeep) else $error("fpu off flag changed");
	property p_irq;
		irq_ack_q |-> $past(evt_req) == 0 && !$past(status_q[0]);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt taken over exception or block");
	property p_rte;
		rte_ack_q |-> $past(evt_req) == 0;
	endproperty
	a_rte: assert property (p_rte) else $error("return taken with event pending");
	property p_ready;
		psel && $rose(penable) |=> pready_q ##1 !pready_q;
	endproperty
	a_ready: assert property (p_ready) else $error("ready timing wrong");
	property p_err;
		pslverr_q |-> pready_q && prdata_q == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("error response malformed");
	c_rst: cover property (exc_ack_q && $past(|evt_req[4:0]));
	c_irq: cover property (irq_ack_q);
	c_rte: cover property (rte_ack_q);
endmodule
bind cxs_exc_seq cxs_exc_seq_checker #(.ADDR_W(ADDR_W), .EV_NUM(EV_NUM)) u_chk (.pclk, .presetn, .psel,
	.penable, .pready_q, .prdata_q, .pslverr_q, .evt_req, .redirect_q, .redirect_pc_q, .exc_ack_q,
	.irq_ack_q, .rte_ack_q, .status_q);
`default_nettype wire

// *** test/cxs_pipe_model.sv ***
// Pipeline model: raises requests and holds them until acknowledged
`timescale 1ns/1ps
`default_nettype none
module cxs_pipe_model (
	input wire pclk,
	input wire presetn,
	input wire go,
	input wire [22:0] vec,
	input wire [1:0] ireq,
	input wire return_from_exc,
	input wire [11:0] code_in,
	input wire [31:0] pc_in,
	input wire ack,
	output logic [22:0] evt_req,
	output logic nmi_req,
	output logic irq_req,
	output logic [11:0] irq_code,
	output logic rte_req,
	output logic [31:0] cur_pc,
	output wire [31:0] next_pc
);
	assign next_pc = cur_pc + 32'h4;
	// Any accept flushes every pending request
	always @(posedge pclk or negedge presetn)
		if (!presetn || ack)
		begin
			evt_req <= 23'h0;
			{nmi_req, irq_req, rte_req} <= 3'h0;
			irq_code <= 12'h0;
			if (!presetn)
				cur_pc <= 32'h0;
		end
		else if (go)
		begin
			evt_req <= vec;
			{nmi_req, irq_req} <= ireq;
			rte_req <= return_from_exc;
			irq_code <= code_in;
			cur_pc <= pc_in;
		end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the exception entry sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, return_from_exc = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, pc_in = 0, seed = 32'hbd97, rd, vb, pc, tgt, r;
	logic [22:0] vec = 0;
	logic [1:0] ireq = 0;
	logic [11:0] code_in = 0, c;
	logic er;
	wire pready_q, pslverr_q, nmi_req, irq_req, rte_req, redirect_q, exc_ack_q, irq_ack_q, rte_ack_q;
	wire [31:0] prdata_q, cur_pc, next_pc, redirect_pc_q, status_q;
	wire [22:0] evt_req;
	wire [11:0] irq_code;
	int bad_count = 0, checks = 0, cyc = 0, nred = 0, n0;
	int evs[23] = '{5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21, 22, 0, 1, 2, 3, 4};
	always #25 pclk = ~pclk;
	cxs_exc_seq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready_q, .prdata_q,
		.pslverr_q, .evt_req, .nmi_req, .irq_req, .irq_code, .rte_req, .cur_pc, .next_pc, .redirect_q,
		.redirect_pc_q, .exc_ack_q, .irq_ack_q, .rte_ack_q, .status_q);
	cxs_pipe_model u_pipe (.pclk, .presetn, .go, .vec, .ireq, .return_from_exc, .code_in, .pc_in,
		.ack(exc_ack_q | irq_ack_q | rte_ack_q), .evt_req, .nmi_req, .irq_req, .irq_code, .rte_req,
		.cur_pc, .next_pc);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [11:0] ecode(input int i);
		case (i)
			0, 1: ecode = 12'h000;
			8, 18: ecode = 12'h0a0;
			19: ecode = 12'h0c0;
			13: ecode = 12'h160;
			20: ecode = 12'h120;
			2: ecode = 12'h020;
			3, 4: ecode = 12'h140;
			5, 22: ecode = 12'h1e0;
			6, 14: ecode = 12'h0e0;
			7, 16: ecode = 12'h040;
			9: ecode = 12'h180;
			10: ecode = 12'h1a0;
			11: ecode = 12'h800;
			12: ecode = 12'h820;
			15: ecode = 12'h100;
			17: ecode = 12'h060;
			21: ecode = 12'h080;
			default: ecode = 12'hfff;
		endcase
	endfunction
	function automatic logic [31:0] etgt(input int i);
		if (i < 5)
			return 32'ha0000000;
		return (i == 7 || i == 16 || i == 17) ? vb + 32'h400 : vb + 32'h100;
	endfunction
	////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp)
		begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a stuck transfer
		do
			@(posedge pclk);
		while (pready_q !== 1'b1);
		rd = prdata_q;
		er = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task raise(input logic [22:0] v, input logic [1:0] q, input logic t, input logic [11:0] k);
		@(posedge pclk);
		go <= 1'b1;
		vec <= v;
		ireq <= q;
		return_from_exc <= t;
		code_in <= k;
		pc_in <= pc;
		@(posedge pclk);
		go <= 1'b0;
	endtask
	task await;
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			n = n + 1;
		end
		while (redirect_q !== 1'b1 && n < 20);
		tgt = redirect_pc_q;
	endtask
	// Pending interrupt rides along to test that exceptions win
	task run(input logic [22:0] v, input int i);
		logic [31:0] st;
		logic [31:0] sp;
		st = rnd() & 32'hf;
		pc = rnd() & 32'hfffffffc;
		sp = (i == 22 || i == 13) ? pc + 32'h4 : pc;
		apb(1'b1, 8'h0c, st);
		raise(v, 2'b01, 1'b0, 12'h0);
		await;
		chk(tgt, etgt(i));
		chk(status_q, i < 5 ? 32'h7 : st | 32'h7);
		rdchk(8'h18, {20'h0, ecode(i)});
		rdchk(8'h10, sp);
		rdchk(8'h14, st);
		raise(23'h0, 2'b00, 1'b1, 12'h0);
		await;
		chk(tgt, sp);
		chk(status_q, st);
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (redirect_q === 1'b1)
			nred <= nred + 1;
		if (cyc == 8000)
		begin
			bad_count = bad_count + 1;
			tally_and_finish;
		end
	end
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(8'h0c, 32'hf);
		rdchk(8'h18, 32'h0);
		apb(1'b0, 8'h24, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		vb = rnd();
		apb(1'b1, 8'h04, vb);
		rdchk(8'h04, vb);
		foreach (evs[k])
			run(23'h1 << evs[k], evs[k]);
		run(23'h200280, 7);
		run(23'h000028, 3);
		apb(1'b1, 8'h0c, 32'h1);
		r = rnd();
		c = r[11:0];
		n0 = nred;
		raise(23'h0, 2'b01, 1'b0, c);
		repeat (8) @(posedge pclk);
		chk(nred, n0);
		apb(1'b1, 8'h0c, 32'h0);
		await;
		chk(tgt, vb + 32'h600);
		chk(status_q, 32'h7);
		rdchk(8'h1c, {20'h0, c});
		rdchk(8'h18, 32'h140);
		apb(1'b1, 8'h0c, 32'h0);
		raise(23'h0, 2'b11, 1'b0, c);
		await;
		rdchk(8'h1c, 32'h1c0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
